// File: rtl/eas_regs.vh
// register map, field layout and codes for element annunciation and source routing
// assumes an apb master on pclk and channel modules that deliver samples on a strobe
`ifndef EAS_REGS_VH
`define EAS_REGS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define EAS_AW 12
`define EAS_ADDR_CTRL 12'h000
`define EAS_ADDR_TARGET 12'h004
`define EAS_ADDR_COMP 12'h008
`define EAS_ADDR_ELEM 12'h010
`define EAS_ADDR_SRC 12'h040
`define EAS_ADDR_BANK 12'h080
`define EAS_ADDR_MS 12'h100
`define EAS_ADDR_RES 12'h180
`define EAS_STRIDE 4

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define EAS_CTRL_TRESET 0
`define EAS_ELEM_MODE 1:0
`define EAS_ELEM_EVEN 2
`define EAS_ELEM_RST 3'h0
`define EAS_SRC_CT1 2:0
`define EAS_SRC_CT2 5:3
`define EAS_SRC_SUB 6
`define EAS_SRC_GND 9:7
`define EAS_SRC_VT 12:10
`define EAS_SRC_AUX 15:13
`define EAS_SRC_SC1 23:16
`define EAS_SRC_SC2 31:24
`define EAS_SRC_RST 32'h8080_0000
`define EAS_SCALE_SHIFT 7
`define EAS_MS_SHIFT 4

// ------------------------------------------------------------
// sizes and codes
// ------------------------------------------------------------
`define EAS_NSRC 6
`define EAS_CH_PER_MOD 8
`define EAS_CH_PER_BANK 4
`define EAS_FOURTH_CH 3
`define EAS_LOW_CH_A 8'h01
`define EAS_LOW_CH_B 8'h05
`define EAS_MODE_DISABLED 2'h0
`define EAS_MODE_SELF 2'h1
`define EAS_MODE_LATCHED 2'h2
`define EAS_PICKUP_EVENT_TAG 2'h1
`define EAS_OPERATE_EVENT_TAG 2'h2
`define EAS_DROPOUT_EVENT_TAG 2'h3

`endif

// File: rtl/eas_element_annunc.v
// one comparator element: run gating, target indication and pending events
// assumes ack bits are only raised for bits that are pending
`timescale 1ns/1ps
`include "eas_regs.vh"
module eas_element_annunc (
    input wire pclk,
    input wire presetn,
    input wire run,
    input wire pickup_in,
    input wire operate_in,
    input wire [1:0] target_mode,
    input wire events_en,
    input wire target_reset,
    input wire [2:0] ack,
    output reg pickup_out,
    output reg operate_out,
    output reg target_out,
    output reg [2:0] pend
);
    wire pk;
    wire opr;
    wire [2:0] evt;

    // comparator held at default while run is low
    assign pk = run & pickup_in;
    assign opr = run & operate_in;
    // bit0 pickup, bit1 operate, bit2 dropout; dropout ignores operate state
    assign evt = events_en ? {~pk & pickup_out, opr & ~operate_out, pk & ~pickup_out} :
        3'h0;

    // state, target and event bookkeeping
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pickup_out <= 1'b0;
            operate_out <= 1'b0;
            target_out <= 1'b0;
            pend <= 3'h0;
        end else begin
            pickup_out <= pk;
            operate_out <= opr;
            // a new event wins over the ack of the same bit
            if (!events_en) begin
                pend <= 3'h0;
            end else begin
                pend <= (pend & ~ack) | evt;
            end
            case (target_mode)
                `EAS_MODE_DISABLED: target_out <= 1'b0;
                `EAS_MODE_SELF: target_out <= opr;
                `EAS_MODE_LATCHED: begin
                    if (target_reset) begin
                        target_out <= opr;
                    end else begin
                        target_out <= target_out | opr;
                    end
                end
                default: target_out <= 1'b0;
            endcase
        end
    end
endmodule

// File: rtl/eas_source_sum.v
// one summed quantity of a source: two scaled ct inputs added or subtracted
// assumes scale factors are unsigned with seven fraction bits
`timescale 1ns/1ps
`include "eas_regs.vh"
module eas_source_sum #(
    parameter W = 16
) (
    input wire pclk,
    input wire presetn,
    input wire enable,
    input wire [W-1:0] in_a,
    input wire [W-1:0] in_b,
    input wire [7:0] scale_a,
    input wire [7:0] scale_b,
    input wire subtract,
    output reg [W+1:0] sum
);
    wire signed [W+8:0] prod_a;
    wire signed [W+8:0] prod_b;
    wire signed [W+1:0] part_a;
    wire signed [W+1:0] part_b;

    // ratio matching before the sum
    assign prod_a = $signed(in_a) * $signed({1'b0, scale_a});
    assign prod_b = $signed(in_b) * $signed({1'b0, scale_b});
    assign part_a = prod_a[W+1+`EAS_SCALE_SHIFT:`EAS_SCALE_SHIFT];
    assign part_b = prod_b[W+1+`EAS_SCALE_SHIFT:`EAS_SCALE_SHIFT];

    // phasor sum or difference by relative polarity
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum <= {(W+2){1'b0}};
        end else if (enable) begin
            sum <= subtract ? part_a - part_b : part_a + part_b;
        end
    end
endmodule

// File: rtl/eas_top.v
// element annunciation and ac source routing with an apb register file
// assumes channel samples arrive together on sample_valid, one clock domain
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "eas_regs.vh"
module eas_top #(
    parameter NELEM = 4,
    parameter NMOD = 3,
    parameter W = 16,
    parameter [23:0] SLOT_LETTERS = 24'h46_4D55
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire sample_valid,
    input wire [8*NMOD*W-1:0] chan_sample,
    input wire [2*NMOD-1:0] bank_is_voltage,
    input wire [NELEM-1:0] elem_run,
    input wire [NELEM-1:0] elem_pickup,
    input wire [NELEM-1:0] elem_operate,
    output reg [NELEM-1:0] elem_pickup_out,
    output reg [NELEM-1:0] elem_operate_out,
    output reg [NELEM-1:0] target_led,
    output reg event_valid,
    output reg [2:0] event_elem,
    output reg [1:0] event_kind,
    output reg [8*NMOD*W-1:0] chan_out,
    output wire [6*4*(W+2)-1:0] src_i,
    output reg [6*4*W-1:0] src_v
);
    localparam NCH = `EAS_CH_PER_MOD * NMOD;
    localparam NBANK = 2 * NMOD;
    localparam SW = W + 2;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // bank numbers run 1..NBANK, 0 means unused; slot order, then low block within a slot
    function [W-1:0] get_chan;
        input [8*NMOD*W-1:0] bus;
        input [2:0] bank;
        input integer ph;
        integer idx;
        begin
            idx = (bank - 1) * `EAS_CH_PER_BANK + ph;
            if (bank == 3'h0 || bank > NBANK) begin
                get_chan = {W{1'b0}};
            end else begin
                get_chan = bus[idx*W +: W];
            end
        end
    endfunction

    // a bank is usable when it exists and has the wanted type
    function bank_ok;
        input [2:0] bank;
        input want_volt;
        input [2*NMOD-1:0] types;
        begin
            if (bank == 3'h0 || bank > NBANK) begin
                bank_ok = 1'b0;
            end else begin
                bank_ok = (types[bank-1] == want_volt);
            end
        end
    endfunction

    // leaky mean square of one sample
    function [31:0] ms_step;
        input [31:0] old;
        input [W-1:0] x;
        reg signed [2*W-1:0] sq;
        begin
            sq = $signed(x) * $signed(x);
            ms_step = old - (old >> `EAS_MS_SHIFT) +
                (sq[31:0] >> `EAS_MS_SHIFT);
        end
    endfunction

    // ------------------------------------------------------------
    // configuration state
    // ------------------------------------------------------------
    reg [2:0] elem_cfg [0:NELEM-1];
    reg [31:0] src_cfg [0:`EAS_NSRC-1];
    reg target_reset;
    reg [31:0] chan_ms [0:NCH-1];
    reg [SW-1:0] bank_res [0:NBANK-1];

    wire [NELEM-1:0] pk_w;
    wire [NELEM-1:0] opr_w;
    wire [NELEM-1:0] tg_w;
    wire [3*NELEM-1:0] pend_w;
    reg [3*NELEM-1:0] ack;

    // ------------------------------------------------------------
    // elements
    // ------------------------------------------------------------
    genvar ge;
    generate
        for (ge = 0; ge < NELEM; ge = ge + 1) begin : g_elem
            eas_element_annunc u_elem (
                .pclk(pclk),
                .presetn(presetn),
                .run(elem_run[ge]),
                .pickup_in(elem_pickup[ge]),
                .operate_in(elem_operate[ge]),
                .target_mode(elem_cfg[ge][`EAS_ELEM_MODE]),
                .events_en(elem_cfg[ge][`EAS_ELEM_EVEN]),
                .target_reset(target_reset),
                .ack(ack[3*ge +: 3]),
                .pickup_out(pk_w[ge]),
                .operate_out(opr_w[ge]),
                .target_out(tg_w[ge]),
                .pend(pend_w[3*ge +: 3])
            );
        end
    endgenerate

    // event arbiter: lowest element first, pickup before operate before dropout
    reg ev_found;
    reg [2:0] ev_elem;
    reg [1:0] ev_kind;
    integer ei;
    always @* begin
        ack = {(3*NELEM){1'b0}};
        ev_found = 1'b0;
        ev_elem = 3'h0;
        ev_kind = 2'h0;
        for (ei = NELEM - 1; ei >= 0; ei = ei - 1) begin
            if (pend_w[3*ei +: 3] != 3'h0) begin
                ev_found = 1'b1;
                ev_elem = ei[2:0];
            end
        end
        if (ev_found) begin
            if (pend_w[3*ev_elem]) begin
                ev_kind = `EAS_PICKUP_EVENT_TAG;
                ack[3*ev_elem] = 1'b1;
            end else if (pend_w[3*ev_elem+1]) begin
                ev_kind = `EAS_OPERATE_EVENT_TAG;
                ack[3*ev_elem+1] = 1'b1;
            end else begin
                ev_kind = `EAS_DROPOUT_EVENT_TAG;
                ack[3*ev_elem+2] = 1'b1;
            end
        end
    end

    // registered element outputs and event record
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            elem_pickup_out <= {NELEM{1'b0}};
            elem_operate_out <= {NELEM{1'b0}};
            target_led <= {NELEM{1'b0}};
            event_valid <= 1'b0;
            event_elem <= 3'h0;
            event_kind <= 2'h0;
        end else begin
            elem_pickup_out <= pk_w;
            elem_operate_out <= opr_w;
            target_led <= tg_w;
            event_valid <= ev_found;
            event_elem <= ev_elem;
            event_kind <= ev_kind;
        end
    end

    // ------------------------------------------------------------
    // input channel processing
    // ------------------------------------------------------------
    // keeps every channel available plus mean square per channel and residual per bank
    integer ci;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_out <= {(NCH*W){1'b0}};
            for (ci = 0; ci < NCH; ci = ci + 1) begin
                chan_ms[ci] <= 32'h0000_0000;
            end
            for (ci = 0; ci < NBANK; ci = ci + 1) begin
                bank_res[ci] <= {SW{1'b0}};
            end
        end else if (sample_valid) begin
            chan_out <= chan_sample;
            for (ci = 0; ci < NCH; ci = ci + 1) begin
                chan_ms[ci] <= ms_step(chan_ms[ci], chan_sample[ci*W +: W]);
            end
            for (ci = 0; ci < NBANK; ci = ci + 1) begin
                // residual_current_sum of the three phase channels
                bank_res[ci] <= {{2{chan_sample[(4*ci+1)*W-1]}}, chan_sample[4*ci*W +: W]} +
                    {{2{chan_sample[(4*ci+2)*W-1]}}, chan_sample[(4*ci+1)*W +: W]} +
                    {{2{chan_sample[(4*ci+3)*W-1]}}, chan_sample[(4*ci+2)*W +: W]};
            end
        end
    end

    // ------------------------------------------------------------
    // sources
    // ------------------------------------------------------------
    genvar gs;
    genvar gp;
    generate
        for (gs = 0; gs < `EAS_NSRC; gs = gs + 1) begin : g_src
            wire [31:0] cfg;
            assign cfg = src_cfg[gs];
            for (gp = 0; gp < 4; gp = gp + 1) begin : g_ph
                wire [W-1:0] a;
                wire [W-1:0] b;
                // phases from ct1 and ct2, fourth from the ground bank
                if (gp < 3) begin : g_phase
                    assign a = bank_ok(cfg[`EAS_SRC_CT1], 1'b0, bank_is_voltage) ?
                        get_chan(chan_sample, cfg[`EAS_SRC_CT1], gp) : {W{1'b0}};
                    assign b = bank_ok(cfg[`EAS_SRC_CT2], 1'b0, bank_is_voltage) ?
                        get_chan(chan_sample, cfg[`EAS_SRC_CT2], gp) : {W{1'b0}};
                end else begin : g_gnd
                    assign a = bank_ok(cfg[`EAS_SRC_GND], 1'b0, bank_is_voltage) ?
                        get_chan(chan_sample, cfg[`EAS_SRC_GND], `EAS_FOURTH_CH) :
                        {W{1'b0}};
                    assign b = {W{1'b0}};
                end
                eas_source_sum #(.W(W)) u_sum (
                    .pclk(pclk),
                    .presetn(presetn),
                    .enable(sample_valid),
                    .in_a(a),
                    .in_b(b),
                    .scale_a(cfg[`EAS_SRC_SC1]),
                    .scale_b(cfg[`EAS_SRC_SC2]),
                    .subtract(cfg[`EAS_SRC_SUB]),
                    .sum(src_i[(gs*4+gp)*SW +: SW])
                );
            end
        end
    endgenerate

    // source voltages: phases of the vt bank, aux from a fourth channel
    integer si;
    integer sp;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_v <= {(6*4*W){1'b0}};
        end else if (sample_valid) begin
            for (si = 0; si < `EAS_NSRC; si = si + 1) begin
                for (sp = 0; sp < 3; sp = sp + 1) begin
                    src_v[(si*4+sp)*W +: W] <=
                        bank_ok(src_cfg[si][`EAS_SRC_VT], 1'b1, bank_is_voltage) ?
                        get_chan(chan_sample, src_cfg[si][`EAS_SRC_VT], sp) :
                        {W{1'b0}};
                end
                src_v[(si*4+3)*W +: W] <=
                    bank_ok(src_cfg[si][`EAS_SRC_AUX], 1'b1, bank_is_voltage) ?
                    get_chan(chan_sample, src_cfg[si][`EAS_SRC_AUX], `EAS_FOURTH_CH) :
                    {W{1'b0}};
            end
        end
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire [31:0] addr32;
    assign addr32 = {20'h0_0000, paddr};
    reg rd_hit;
    reg [31:0] rd_data;
    integer di;
    always @* begin
        rd_hit = 1'b0;
        rd_data = 32'h0000_0000;
        if (paddr == `EAS_ADDR_CTRL) begin
            rd_hit = 1'b1;
        end
        if (paddr == `EAS_ADDR_TARGET) begin
            rd_hit = 1'b1;
            rd_data[NELEM-1:0] = target_led;
        end
        if (paddr == `EAS_ADDR_COMP) begin
            rd_hit = 1'b1;
            rd_data[NELEM-1:0] = elem_pickup_out;
            rd_data[8 +: NELEM] = elem_operate_out;
        end
        for (di = 0; di < NELEM; di = di + 1) begin
            if (addr32 == `EAS_ADDR_ELEM + di * `EAS_STRIDE) begin
                rd_hit = 1'b1;
                rd_data[2:0] = elem_cfg[di];
            end
        end
        for (di = 0; di < `EAS_NSRC; di = di + 1) begin
            if (addr32 == `EAS_ADDR_SRC + di * `EAS_STRIDE) begin
                rd_hit = 1'b1;
                rd_data = src_cfg[di];
            end
        end
        for (di = 0; di < NBANK; di = di + 1) begin
            if (addr32 == `EAS_ADDR_BANK + di * `EAS_STRIDE) begin
                rd_hit = 1'b1;
                rd_data[15:8] = SLOT_LETTERS[8*(NMOD-1-di/2) +: 8];
                rd_data[7:0] = di[0] ? `EAS_LOW_CH_B : `EAS_LOW_CH_A;
            end
            if (addr32 == `EAS_ADDR_RES + di * `EAS_STRIDE) begin
                rd_hit = 1'b1;
                rd_data = {{(32-SW){bank_res[di][SW-1]}}, bank_res[di]};
            end
        end
        for (di = 0; di < NCH; di = di + 1) begin
            if (addr32 == `EAS_ADDR_MS + di * `EAS_STRIDE) begin
                rd_hit = 1'b1;
                rd_data = chan_ms[di];
            end
        end
    end

    // ------------------------------------------------------------
    // apb slave: answer ready one cycle after setup
    // ------------------------------------------------------------
    wire setup;
    wire wr_take;
    assign setup = psel & ~penable;
    assign wr_take = psel & penable & pready & pwrite & ~pslverr;
    integer wi;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            target_reset <= 1'b0;
            for (wi = 0; wi < NELEM; wi = wi + 1) begin
                elem_cfg[wi] <= `EAS_ELEM_RST;
            end
            for (wi = 0; wi < `EAS_NSRC; wi = wi + 1) begin
                src_cfg[wi] <= `EAS_SRC_RST;
            end
        end else begin
            target_reset <= 1'b0;
            if (setup) begin
                pready <= 1'b1;
                pslverr <= ~rd_hit;
                prdata <= pwrite ? 32'h0000_0000 : rd_data;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
            if (wr_take) begin
                if (paddr == `EAS_ADDR_CTRL) begin
                    target_reset <= pwdata[`EAS_CTRL_TRESET];
                end
                for (wi = 0; wi < NELEM; wi = wi + 1) begin
                    if (addr32 == `EAS_ADDR_ELEM + wi * `EAS_STRIDE) begin
                        elem_cfg[wi] <= pwdata[2:0];
                    end
                end
                for (wi = 0; wi < `EAS_NSRC; wi = wi + 1) begin
                    if (addr32 == `EAS_ADDR_SRC + wi * `EAS_STRIDE) begin
                        src_cfg[wi] <= pwdata;
                    end
                end
            end
        end
    end
endmodule

// File: tb/eas_top_chk.sv
// assertions on eas_top ports: apb answers, element outputs, events
// assumes bind to eas_top, one clock, reset low while asserted
`timescale 1ns/1ps
module eas_top_chk #(
    parameter NELEM = 4
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [NELEM-1:0] elem_run,
    input wire [NELEM-1:0] elem_pickup,
    input wire [NELEM-1:0] elem_operate,
    input wire [NELEM-1:0] elem_pickup_out,
    input wire [NELEM-1:0] elem_operate_out,
    input wire [NELEM-1:0] target_led,
    input wire event_valid,
    input wire [1:0] event_kind
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // register bus answers
    // ----------------------------------------
    // setup answered next cycle, access lasts one cycle
    chk_apb_answer: assert property (psel && !penable |=> pready)
        else $error("setup not answered");
    chk_apb_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    // refusal only inside an access, writes return zero
    chk_err_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside access");
    chk_wr_zero: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
        else $error("read data on write");
    // ----------------------------------------
    // element outputs
    // ----------------------------------------
    // outputs are run-gated inputs two cycles on
    chk_pick_follow: assert property ($past(presetn) && $past(presetn, 2)
        |-> elem_pickup_out == ($past(elem_run, 2) & $past(elem_pickup, 2)))
        else $error("pickup output not gated by run");
    chk_oper_follow: assert property ($past(presetn) && $past(presetn, 2)
        |-> elem_operate_out == ($past(elem_run, 2) & $past(elem_operate, 2)))
        else $error("operate output not gated by run");
    // a target only rises behind an operate
    chk_target_cause: assert property ($past(presetn) && $past(presetn, 2)
        |-> (target_led & ~$past(target_led) & ~$past(elem_run & elem_operate, 2)) == '0)
        else $error("target without operate");
    chk_event_kind: assert property (event_valid |-> event_kind != 2'h0)
        else $error("event without kind");
endmodule

// File: tb/eas_chan_model.sv
// ct/vt channel module model: sample strobe, channel words, bank types
// assumes the bench hands over a full sample set with a one-cycle load
`timescale 1ns/1ps
module eas_chan_model #(
    parameter NB = 384,
    parameter [5:0] VMASK = 6'h0a
) (
    input wire pclk,
    input wire presetn,
    input wire load,
    input wire [NB-1:0] data,
    output reg sample_valid,
    output reg [NB-1:0] chan_sample,
    output wire [5:0] bank_is_voltage
);
    // fixed bank types, one type per bank of four
    assign bank_is_voltage = VMASK;
    // one strobe per set; words scrambled between strobes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_valid <= 1'b0;
            chan_sample <= {NB{1'b0}};
        end else begin
            sample_valid <= load;
            chan_sample <= load ? data : ~chan_sample;
        end
    end
endmodule

// File: tb/element_annunciation_source_routing_tb.sv
// bench for eas_top: registers, targets, events, source sums
// assumes eas_top defaults: four elements, three modules, 16-bit words
`timescale 1ns/1ps
`include "eas_regs.vh"
module element_annunciation_source_routing_tb;
    localparam NB = 384;
    localparam [23:0] LET = 24'h46_4d55;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, load = 0, err;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rd, cfg;
    reg [3:0] run = 0, pick = 0, oper = 0;
    reg [NB-1:0] smp = 0;
    reg [4:0] evq[$];
    integer seed = 32'h0000_07e2, fail_count = 0, checks_done = 0, i, m;
    wire [31:0] prdata;
    wire pready, pslverr, sample_valid, event_valid;
    wire [NB-1:0] chan_sample;
    wire [5:0] bank_is_voltage;
    wire [3:0] pick_out, oper_out, target_led;
    wire [2:0] event_elem;
    wire [1:0] event_kind;
    wire [431:0] src_i;
    wire [383:0] src_v, chan_out;
    eas_chan_model #(.NB(NB), .VMASK(6'h0a)) u_chan (.pclk(pclk), .presetn(presetn),
        .load(load), .data(smp), .sample_valid(sample_valid), .chan_sample(chan_sample),
        .bank_is_voltage(bank_is_voltage));
    eas_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid), .chan_sample(chan_sample),
        .bank_is_voltage(bank_is_voltage), .elem_run(run), .elem_pickup(pick),
        .elem_operate(oper), .elem_pickup_out(pick_out), .elem_operate_out(oper_out),
        .target_led(target_led), .event_valid(event_valid), .event_elem(event_elem),
        .event_kind(event_kind), .chan_out(chan_out), .src_i(src_i), .src_v(src_v));
    // ----------------------------------------
    // clock, event log, helpers
    // ----------------------------------------
    always #10 pclk = ~pclk;
    // every reported event, element and kind
    always @(posedge pclk) if (event_valid === 1'b1) evq.push_back({event_elem, event_kind});
    function integer ch(input integer c);
        ch = $signed(smp[c*16+:16]);
    endfunction
    // scaled sum with the source's current scales and sign
    function [17:0] ei(input integer a, input integer b);
        ei = ((a * cfg[23:16]) >>> 7) + (cfg[6] ? -((b * cfg[31:24]) >>> 7) : ((b * cfg[31:24]) >>> 7));
    endfunction
    task chk(input [31:0] g, input [31:0] e);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer, held until ready is sampled
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d fails %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        cyc(3);
        presetn <= 1'b1;
        apb(0, `EAS_ADDR_SRC, 0);
        chk(rd, 32'h8080_0000);
        for (i = 0; i < 6; i = i + 1) begin
            apb(0, `EAS_ADDR_BANK + 4 * i, 0);
            chk(rd, {16'h0000, LET[(2 - i / 2) * 8 +: 8], (i % 2) ? 8'h05 : 8'h01});
        end
        apb(1, 12'h058, 32'hffff_ffff);
        chk(err, 1'b1);
        // target modes on element 0, then latched clear
        for (m = 0; m < 3; m = m + 1) begin
            apb(1, `EAS_ADDR_ELEM, m);
            run <= 4'h1;
            oper <= 4'h1;
            cyc(4);
            chk(target_led[0], m != 0);
            oper <= 4'h0;
            cyc(4);
            chk(target_led[0], m == 2);
        end
        apb(1, `EAS_ADDR_CTRL, 1);
        cyc(3);
        chk(target_led[0], 1'b0);
        oper <= 4'h1;
        cyc(4);
        apb(1, `EAS_ADDR_CTRL, 1);
        cyc(3);
        chk(target_led[0], 1'b1);
        // run gating
        oper <= 4'h0;
        run <= 4'h0;
        pick <= 4'h1;
        cyc(4);
        chk(pick_out[0], 1'b0);
        run <= 4'h1;
        cyc(4);
        chk(pick_out[0], 1'b1);
        // events on element 1 only, dropout while operating
        apb(1, `EAS_ADDR_ELEM + 4, 32'h0000_0004);
        evq.delete();
        run <= 4'hf;
        pick <= 4'h6;
        cyc(5);
        oper <= 4'h6;
        cyc(5);
        pick <= 4'h0;
        cyc(5);
        oper <= 4'h0;
        cyc(6);
        chk(evq.size(), 3);
        for (i = 0; i < 3; i = i + 1) chk(evq[i], {3'h1, i[1:0] + 2'h1});
        // source 0: ct banks 1 and 3, ground 1, vt 2, aux 4; first set at extremes
        for (m = 0; m < 5; m = m + 1) begin
            for (i = 0; i < 12; i = i + 1) smp[i*32+:32] = $random(seed);
            cfg = $random(seed);
            if (m == 0) smp = {24{16'h8000}};
            if (m == 0) cfg[31:16] = 16'hffff;
            cfg[15:0] = {3'h4, 3'h2, 3'h1, cfg[6], 3'h3, 3'h1};
            apb(1, `EAS_ADDR_SRC, cfg);
            load <= 1'b1;
            @(posedge pclk);
            load <= 1'b0;
            cyc(3);
            for (i = 0; i < 3; i = i + 1) begin
                chk(src_i[i*18+:18], ei(ch(i), ch(8 + i)));
                chk(src_v[i*16+:16], smp[(4 + i)*16+:16]);
                chk(chan_out[i*128+:32], smp[i*128+:32]);
            end
            chk(src_i[54+:18], ei(ch(3), 0));
            chk(src_v[48+:16], smp[240+:16]);
            apb(0, `EAS_ADDR_RES, 0);
            chk(rd, ch(0) + ch(1) + ch(2));
            if (m == 0) apb(0, `EAS_ADDR_MS, 0);
            if (m == 0) chk(rd, 32'h0400_0000);
        end
        // random element traffic for the checker
        apb(1, `EAS_ADDR_ELEM + 8, 32'h0000_0005);
        for (i = 0; i < 300; i = i + 1) begin
            @(posedge pclk);
            {run, pick, oper} <= $random(seed);
        end
        end_sim;
    end
    // hang guard
    initial begin
        #400000;
        fail_count = fail_count + 1;
        end_sim;
    end
endmodule
bind eas_top eas_top_chk #(.NELEM(NELEM)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .elem_run(elem_run), .elem_pickup(elem_pickup),
    .elem_operate(elem_operate), .elem_pickup_out(elem_pickup_out),
    .elem_operate_out(elem_operate_out), .target_led(target_led),
    .event_valid(event_valid), .event_kind(event_kind));
